// ### vic_map.svh
// vic_map.svh: offsets, field positions, reset values and source counts
// assumes: included by bare name from vic_pkg and vic_ctrl
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

// register indices; byte address on the bus is four times the index
`define VIC_SYSCTL_IDX 16'hFFC4
`define VIC_SENSE_IDX 16'hFFC6
`define VIC_ENABLE_IDX 16'hFFC7
`define VIC_COND_IDX 16'hFFC8
`define VIC_INTEN_IDX 16'hFFC9
`define VIC_STATUS_IDX 16'hFFCA

`define VIC_ADDR_W 18

// system control fields
`define VIC_SYSCTL_NMI_EDGE 2
`define VIC_SYSCTL_RST 8'h0B
`define VIC_SYSCTL_WMASK 8'hF5
`define VIC_SYSCTL_FIXED 8'h0A

// sense and line-enable registers
`define VIC_EXT_RST 3'h0
`define VIC_EXT_FIXED 8'hF8

// condition byte: mask bit position and reset value
`define VIC_COND_IBIT 7
`define VIC_COND_RST 8'h80

`define VIC_INTEN_RST 19'h00000

// vector numbers
`define VIC_VEC_NMI 6'h03
`define VIC_VEC_EXT0 6'h04
`define VIC_VEC_TMR16 6'h0C
`define VIC_VEC_SERIAL 6'h1B
`define VIC_VEC_CONV 6'h23
`define VIC_VEC_WDOG 6'h24
`define VIC_VEC_NONE 6'h00

// counts of internal sources per block
`define VIC_N_TMR 13
`define VIC_N_SERIAL 4

// bus responses
`define VIC_RESP_OKAY 2'h0
`define VIC_RESP_SLVERR 2'h2

`endif

// ### vic_pkg.sv
// vic_pkg.sv: types shared by the vectored interrupt controller
// assumes: vic_map.svh sits in the same folder
`include "vic_map.svh"

package vic_pkg;

  localparam int N_EXT = 3;
  localparam int N_INT = 19;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_PUSH_PC = 4'h2,
    SEQ_PUSH_COND = 4'h4,
    SEQ_VECTOR = 4'h8
  } vic_seq_t;

  typedef struct packed {
    logic aw_held;
    logic [`VIC_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vic_bus_t;

  typedef struct packed {
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    logic [N_EXT-1:0] ext_s1;
    logic [N_EXT-1:0] ext_s2;
    logic [N_EXT-1:0] ext_prev;
    logic hws_s1;
    logic hws_s2;
  } vic_sync_t;

  typedef struct packed {
    vic_bus_t bus;
    vic_sync_t sy;
    logic [7:0] sysctl;
    logic [N_EXT-1:0] sense;
    logic [N_EXT-1:0] line_en;
    logic [N_INT-1:0] int_en;
    logic [7:0] cond;
    logic first_done;
    logic nmi_pend;
    logic [N_EXT-1:0] ext_pend;
    vic_seq_t seq;
    logic [5:0] vec;
    logic req;
    logic [5:0] req_vec;
    logic stack_wr;
    logic [15:0] stack_data;
    logic vec_load;
    logic [15:0] vec_addr;
    logic wake;
  } vic_state_t;

endpackage

// ### vic_ctrl.sv
// vic_ctrl.sv: vectored interrupt controller with its exception sequencer
// assumes: one 20 MHz clock, synchronous active-low reset, AXI4-Lite master,
// internal requests arrive on this clock; external pins are asynchronous
//
// Notes on behaviour
// - nmi request on falling edge when edge select is 0, rising when 1
// - nmi ignores mask bit, uses vector 3, its sequence sets mask bit
// - each external line is low-level sensed when select 0, falling edge when 1
// - each external line has its own enable bit, all cleared at reset
// - edge caught while enabled stays pending even after enable is cleared
// - pending external flag clears when mask set, level mode and disabled
// - external lines use vectors 4 to 6, line 0 highest priority
// - nineteen internal sources have vectors 12 to 36, masked by mask bit
// - internal vectors: timers 12 to 24, serial 27 to 30, 35, 36
// - maskable request taken only when mask bit clear and either enabled or its edge already pending
// - nmi accepted always except in reset, hardware standby or before the first instruction completes
// - only highest priority accepted request passed on; lower vector wins
// - sequence starts after current instruction or sequence; vector latched
// - sequence pushes program counter first, then condition byte
// - after stacking the mask bit is set to 1
// - vector address is twice the vector number, table starts at zero
// - condition byte stacked twice; return restores it from even byte
// - detection ignores pin direction settings
// - nmi and external lines can wake from software standby
// - bits 7 to 3 of sense and enable registers read as 1
// - all requests blocked after reset until first instruction completes
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.svh"

module vic_ctrl #(
  parameter int N_EXT = vic_pkg::N_EXT,
  parameter int N_INT = vic_pkg::N_INT
) (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  // register bus
  input wire logic [`VIC_ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [`VIC_ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // request pins
  input wire logic NMI_N_I,
  input wire logic [N_EXT-1:0] EXT_REQ_N_I,
  input wire logic [N_INT-1:0] INT_REQ_I,
  // core side
  input wire logic INSTR_END_I,
  input wire logic [15:0] NEXT_PC_I,
  input wire logic RETURN_I,
  input wire logic [15:0] RETURN_WORD_I,
  input wire logic SW_STANDBY_I,
  input wire logic HW_STANDBY_I,
  output logic REQ_O,
  output logic [5:0] REQ_VEC_O,
  output logic STACK_WR_O,
  output logic [15:0] STACK_DATA_O,
  output logic VEC_LOAD_O,
  output logic [15:0] VEC_ADDR_O,
  output logic [7:0] COND_O,
  output logic WAKE_O
);

  vic_pkg::vic_state_t q;
  vic_pkg::vic_state_t next_q;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [`VIC_ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic [5:0] int_vec(input int i);
    if (i < `VIC_N_TMR) begin
      int_vec = `VIC_VEC_TMR16 + 6'(i);
    end else if (i < `VIC_N_TMR + `VIC_N_SERIAL) begin
      int_vec = `VIC_VEC_SERIAL + 6'(i - `VIC_N_TMR);
    end else if (i == `VIC_N_TMR + `VIC_N_SERIAL) begin
      int_vec = `VIC_VEC_CONV;
    end else begin
      int_vec = `VIC_VEC_WDOG;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset image

  vic_pkg::vic_state_t rst_q;
  always_comb begin
    rst_q = '0;
    rst_q.bus.awready = 1'b1;
    rst_q.bus.wready = 1'b1;
    rst_q.bus.arready = 1'b1;
    rst_q.sy.nmi_s1 = 1'b1;
    rst_q.sy.nmi_s2 = 1'b1;
    rst_q.sy.nmi_prev = 1'b1;
    rst_q.sy.ext_s1 = '1;
    rst_q.sy.ext_s2 = '1;
    rst_q.sy.ext_prev = '1;
    rst_q.sysctl = `VIC_SYSCTL_RST;
    rst_q.sense = `VIC_EXT_RST;
    rst_q.line_en = `VIC_EXT_RST;
    rst_q.int_en = `VIC_INTEN_RST;
    rst_q.cond = `VIC_COND_RST;
    rst_q.seq = vic_pkg::SEQ_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  logic nmi_sel;
  logic [N_EXT-1:0] ext_req;
  logic [N_INT-1:0] int_req;
  logic mask;
  logic win;
  logic [5:0] win_vec;

  always_comb begin
    mask = q.cond[`VIC_COND_IBIT];
    for (int k = 0; k < N_EXT; k++) begin
      ext_req[k] = q.sense[k] ? q.ext_pend[k] : (~q.sy.ext_s2[k] & q.line_en[k]);
    end
    int_req = INT_REQ_I & q.int_en;
    win = 1'b0;
    win_vec = `VIC_VEC_NONE;
    // lowest vector scanned last so it wins
    if (q.first_done && !mask) begin
      for (int i = N_INT - 1; i >= 0; i--) begin
        if (int_req[i]) begin
          win = 1'b1;
          win_vec = int_vec(i);
        end
      end
      for (int k = N_EXT - 1; k >= 0; k--) begin
        if (ext_req[k]) begin
          win = 1'b1;
          win_vec = `VIC_VEC_EXT0 + 6'(k);
        end
      end
    end
    // hardware standby blocks nmi; reset clears everything anyway
    nmi_sel = q.nmi_pend & q.first_done & ~q.sy.hws_s2;
    if (nmi_sel) begin
      win = 1'b1;
      win_vec = `VIC_VEC_NMI;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_hit;
  logic take;

  always_comb begin
    next_q = q;
    wr_val = 32'h0000_0000;
    rd_val = 32'h0000_0000;
    rd_hit = 1'b0;
    take = 1'b0;
    next_q.stack_wr = 1'b0;
    next_q.vec_load = 1'b0;

    // pin levels only, no direction involved
    next_q.sy.nmi_s1 = NMI_N_I;
    next_q.sy.nmi_s2 = q.sy.nmi_s1;
    next_q.sy.nmi_prev = q.sy.nmi_s2;
    next_q.sy.ext_s1 = EXT_REQ_N_I;
    next_q.sy.ext_s2 = q.sy.ext_s1;
    next_q.sy.ext_prev = q.sy.ext_s2;
    next_q.sy.hws_s1 = HW_STANDBY_I;
    next_q.sy.hws_s2 = q.sy.hws_s1;

    // write channel: address and data taken in either order
    if (AWVALID_I && q.bus.awready) begin
      next_q.bus.aw_held = 1'b1;
      next_q.bus.aw_addr = AWADDR_I;
    end
    if (WVALID_I && q.bus.wready) begin
      next_q.bus.w_held = 1'b1;
      next_q.bus.w_data = WDATA_I;
      next_q.bus.w_strb = WSTRB_I;
    end
    if (q.bus.bvalid && BREADY_I) begin
      next_q.bus.bvalid = 1'b0;
    end
    if (q.bus.aw_held && q.bus.w_held && !q.bus.bvalid) begin
      next_q.bus.aw_held = 1'b0;
      next_q.bus.w_held = 1'b0;
      next_q.bus.bvalid = 1'b1;
      next_q.bus.bresp = `VIC_RESP_OKAY;
      unique case (q.bus.aw_addr)
        byte_addr(`VIC_SYSCTL_IDX): begin
          wr_val = merge({24'h0, q.sysctl}, q.bus.w_data, q.bus.w_strb);
          next_q.sysctl = (wr_val[7:0] & `VIC_SYSCTL_WMASK) |
                          (q.sysctl & ~`VIC_SYSCTL_WMASK);
        end
        byte_addr(`VIC_SENSE_IDX): begin
          wr_val = merge({29'h0, q.sense}, q.bus.w_data, q.bus.w_strb);
          next_q.sense = wr_val[2:0];
        end
        byte_addr(`VIC_ENABLE_IDX): begin
          wr_val = merge({29'h0, q.line_en}, q.bus.w_data, q.bus.w_strb);
          next_q.line_en = wr_val[2:0];
        end
        byte_addr(`VIC_COND_IDX): begin
          wr_val = merge({24'h0, q.cond}, q.bus.w_data, q.bus.w_strb);
          next_q.cond = wr_val[7:0];
        end
        byte_addr(`VIC_INTEN_IDX): begin
          wr_val = merge({13'h0, q.int_en}, q.bus.w_data, q.bus.w_strb);
          next_q.int_en = wr_val[18:0];
        end
        byte_addr(`VIC_STATUS_IDX): begin
          wr_val = 32'h0000_0000;
        end
        default: begin
          next_q.bus.bresp = `VIC_RESP_SLVERR;
        end
      endcase
    end

    // read channel
    unique case (ARADDR_I)
      byte_addr(`VIC_SYSCTL_IDX): begin
        rd_hit = 1'b1;
        rd_val = {24'h0, q.sysctl | `VIC_SYSCTL_FIXED};
      end
      byte_addr(`VIC_SENSE_IDX): begin
        rd_hit = 1'b1;
        rd_val = {24'h0, `VIC_EXT_FIXED | {5'h00, q.sense}};
      end
      byte_addr(`VIC_ENABLE_IDX): begin
        rd_hit = 1'b1;
        rd_val = {24'h0, `VIC_EXT_FIXED | {5'h00, q.line_en}};
      end
      byte_addr(`VIC_COND_IDX): begin
        rd_hit = 1'b1;
        rd_val = {24'h0, q.cond};
      end
      byte_addr(`VIC_INTEN_IDX): begin
        rd_hit = 1'b1;
        rd_val = {13'h0, q.int_en};
      end
      byte_addr(`VIC_STATUS_IDX): begin
        rd_hit = 1'b1;
        rd_val = {16'h0, q.seq != vic_pkg::SEQ_IDLE, q.first_done, q.vec,
                  3'h0, q.nmi_pend, 1'b0, q.ext_pend};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (q.bus.rvalid && RREADY_I) begin
      next_q.bus.rvalid = 1'b0;
    end
    if (ARVALID_I && q.bus.arready) begin
      next_q.bus.rvalid = 1'b1;
      next_q.bus.rdata = rd_val;
      next_q.bus.rresp = rd_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
    end
    next_q.bus.awready = ~next_q.bus.aw_held & ~next_q.bus.bvalid;
    next_q.bus.wready = ~next_q.bus.w_held & ~next_q.bus.bvalid;
    next_q.bus.arready = ~next_q.bus.rvalid;

    // first instruction after reset always runs
    if (INSTR_END_I) begin
      next_q.first_done = 1'b1;
    end

    // return restores condition from the even (high) byte
    if (RETURN_I) begin
      next_q.cond = RETURN_WORD_I[15:8];
    end

    // exception sequencer
    take = win & ((q.seq == vic_pkg::SEQ_IDLE && INSTR_END_I) ||
                  q.seq == vic_pkg::SEQ_VECTOR);
    unique case (q.seq)
      vic_pkg::SEQ_PUSH_PC: begin
        next_q.stack_wr = 1'b1;
        next_q.stack_data = {q.cond, q.cond};
        next_q.seq = vic_pkg::SEQ_PUSH_COND;
      end
      vic_pkg::SEQ_PUSH_COND: begin
        next_q.cond[`VIC_COND_IBIT] = 1'b1;
        next_q.vec_load = 1'b1;
        next_q.vec_addr = {9'h000, q.vec, 1'b0};
        next_q.seq = vic_pkg::SEQ_VECTOR;
      end
      vic_pkg::SEQ_VECTOR,
      vic_pkg::SEQ_IDLE: begin
        next_q.seq = vic_pkg::SEQ_IDLE;
      end
    endcase
    if (take) begin
      next_q.vec = win_vec;
      next_q.stack_wr = 1'b1;
      next_q.stack_data = NEXT_PC_I;
      next_q.seq = vic_pkg::SEQ_PUSH_PC;
    end

    // pending flags: clears first, sets afterwards so a new event wins
    if (take && win_vec == `VIC_VEC_NMI) begin
      next_q.nmi_pend = 1'b0;
    end
    if (q.sysctl[`VIC_SYSCTL_NMI_EDGE] ? (~q.sy.nmi_prev & q.sy.nmi_s2)
                                   : (q.sy.nmi_prev & ~q.sy.nmi_s2)) begin
      next_q.nmi_pend = 1'b1;
    end
    for (int k = 0; k < N_EXT; k++) begin
      if (take && win_vec == `VIC_VEC_EXT0 + 6'(k)) begin
        next_q.ext_pend[k] = 1'b0;
      end
      if (mask && !q.sense[k] && !q.line_en[k]) begin
        next_q.ext_pend[k] = 1'b0;
      end
      // enable gates only new edges; a caught edge survives disabling
      if (q.sense[k] && q.line_en[k] && q.sy.ext_prev[k] && !q.sy.ext_s2[k]) begin
        next_q.ext_pend[k] = 1'b1;
      end
    end

    // request to core shows the arbitration result
    next_q.req = win & (next_q.seq == vic_pkg::SEQ_IDLE);
    next_q.req_vec = win_vec;
    // wake from software standby on nmi or any enabled external request
    next_q.wake = SW_STANDBY_I & (q.nmi_pend | (|(ext_req & (q.line_en | q.ext_pend))));
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      q <= rst_q;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign AWREADY_O = q.bus.awready;
  assign WREADY_O = q.bus.wready;
  assign BVALID_O = q.bus.bvalid;
  assign BRESP_O = q.bus.bresp;
  assign ARREADY_O = q.bus.arready;
  assign RVALID_O = q.bus.rvalid;
  assign RDATA_O = q.bus.rdata;
  assign RRESP_O = q.bus.rresp;
  assign REQ_O = q.req;
  assign REQ_VEC_O = q.req_vec;
  assign STACK_WR_O = q.stack_wr;
  assign STACK_DATA_O = q.stack_data;
  assign VEC_LOAD_O = q.vec_load;
  assign VEC_ADDR_O = q.vec_addr;
  assign COND_O = q.cond;
  assign WAKE_O = q.wake;

endmodule

`default_nettype wire

// ### vic_ctrl_asserts.sv
// vic_ctrl_asserts.sv: timing checks on the core link of vic_ctrl
// assumes: bound onto vic_ctrl, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl_asserts (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic INSTR_END_I,
  input wire logic [15:0] NEXT_PC_I,
  input wire logic REQ_O,
  input wire logic [5:0] REQ_VEC_O,
  input wire logic STACK_WR_O,
  input wire logic [15:0] STACK_DATA_O,
  input wire logic VEC_LOAD_O,
  input wire logic [15:0] VEC_ADDR_O,
  input wire logic [7:0] COND_O
);
  logic seen;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  ////////////////////////////////////////
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      seen <= 1'b0;
    end else if (INSTR_END_I) begin
      seen <= 1'b1;
    end
  end
  sequence s_start;
    REQ_O && INSTR_END_I;
  endsequence
  sequence s_stack;
    STACK_WR_O ##1 STACK_WR_O && STACK_DATA_O[15:8] == STACK_DATA_O[7:0];
  endsequence
  ////////////////////////////////////////
  AST_PC_FIRST: assert property (
    s_start |=> STACK_WR_O && STACK_DATA_O == $past(NEXT_PC_I)) else $error("stacked pc wrong");
  AST_COND_TWICE: assert property (
    s_start |=> s_stack) else $error("condition word not doubled");
  AST_MASK_SET: assert property (
    s_start |-> ##3 VEC_LOAD_O && COND_O[7]) else $error("mask bit not set at vector");
  AST_VEC_ADDR: assert property (
    s_start |-> ##3 VEC_ADDR_O == {9'h000, $past(REQ_VEC_O, 3), 1'b0})
    else $error("vector address wrong");
  AST_HOLD_OFF: assert property (
    s_start |=> !REQ_O [*2]) else $error("request shown during sequence");
  AST_FIRST_INSTR: assert property (
    !seen |-> !REQ_O && !STACK_WR_O) else $error("request before first instruction");
  AST_ONLY_NMI_MASKED: assert property (
    REQ_O && COND_O[7] && $past(COND_O[7]) |-> REQ_VEC_O == 6'h03)
    else $error("maskable request while masked");
  AST_VEC_RANGE: assert property (
    REQ_O |-> REQ_VEC_O inside {[6'h03:6'h06], [6'h0C:6'h18], [6'h1B:6'h1E], 6'h23, 6'h24})
    else $error("vector number out of table");
endmodule
bind vic_ctrl vic_ctrl_asserts u_chk (.REF_CLK_I, .RESETN_I, .INSTR_END_I, .NEXT_PC_I,
  .REQ_O, .REQ_VEC_O, .STACK_WR_O, .STACK_DATA_O, .VEC_LOAD_O, .VEC_ADDR_O, .COND_O);
`default_nettype wire

// ### vic_core_model.sv
// vic_core_model.sv: core stand-in ending instructions and returning from handlers
// assumes: shares the system clock; handler runs a fixed count after the vector load
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic stack_wr_i,
  input wire logic [15:0] stack_data_i,
  input wire logic vec_load_i,
  output logic instr_end_o,
  output logic ret_o,
  output logic [15:0] ret_word_o
);
  logic [4:0] gap = 5'h00;
  logic [4:0] hcnt = 5'h00;
  logic busy = 1'b0;
  logic [7:0] saved = 8'h00;
  initial {instr_end_o, ret_o, ret_word_o} = 18'h00000;
  always @(posedge clk_i) begin
    instr_end_o <= 1'b0;
    ret_o <= 1'b0;
    gap <= gap + 5'h01;
    if (run_i && gap >= (slow_i ? 5'h04 : 5'h01)) begin
      instr_end_o <= 1'b1;
      gap <= 5'h00;
    end
    if (stack_wr_i) saved <= stack_data_i[15:8];
    if (vec_load_i) busy <= 1'b1;
    hcnt <= busy ? hcnt + 5'h01 : 5'h00;
    // odd byte inverted so a design that restores from it is caught
    if (busy && hcnt == (slow_i ? 5'h18 : 5'h0A)) begin
      ret_o <= 1'b1;
      ret_word_o <= {saved, ~saved};
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### test_vectored_interrupt_controller.sv
// test_vectored_interrupt_controller.sv: self-checking bench for vic_ctrl
// assumes: vic_pkg, the checker and vic_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "vic_map.svh"
module test_vectored_interrupt_controller;
  logic clk, rstn, awv, wv, bready, arv, rready, nmi_n, instr_end, ret, sw_sb, run, slow;
  logic awr, wr_rdy, bvalid, arr, rvalid, req, stk_wr, vload, wake, hw_sb;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [18:0] int_req, en;
  logic [15:0] pc, ret_word, stk, vaddr;
  logic [1:0] bresp, rresp;
  logic [2:0] ext_n;
  logic [5:0] rvec;
  logic [7:0] cond;
  logic [33:0] exp_rd[$];
  logic [15:0] exp_vec[$];
  int n_fail = 0, n_tests = 0, cyc = 0, seed = 6, k;
  vic_ctrl uut (.REF_CLK_I(clk), .RESETN_I(rstn), .AWADDR_I(awaddr), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wr_rdy),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .NMI_N_I(nmi_n), .EXT_REQ_N_I(ext_n), .INT_REQ_I(int_req),
    .INSTR_END_I(instr_end), .NEXT_PC_I(pc), .RETURN_I(ret), .RETURN_WORD_I(ret_word),
    .SW_STANDBY_I(sw_sb), .HW_STANDBY_I(hw_sb), .REQ_O(req), .REQ_VEC_O(rvec),
    .STACK_WR_O(stk_wr), .STACK_DATA_O(stk), .VEC_LOAD_O(vload), .VEC_ADDR_O(vaddr),
    .COND_O(cond), .WAKE_O(wake));
  vic_core_model partner (.clk_i(clk), .run_i(run && !sw_sb), .slow_i(slow),
    .stack_wr_i(stk_wr), .stack_data_i(stk), .vec_load_i(vload), .instr_end_o(instr_end),
    .ret_o(ret), .ret_word_o(ret_word));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pc <= 16'($random(seed));
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  // results are judged at the falling edge, where outputs have settled
  always @(negedge clk) begin
    if (rvalid && rready) begin
      chk("read", {rresp, rdata}, exp_rd.size() ? exp_rd.pop_front() : 34'h3FFFFFFFF);
    end
    if (vload) begin
      chk("vector", 34'(vaddr), exp_vec.size() ? 34'(exp_vec.pop_front()) : 34'h0FFFF);
    end
  end
  ////////////////////////////////////////
  task automatic wr(input logic [15:0] idx, input logic [31:0] v, input logic [1:0] eb);
    logic ta, tw, done;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr_rdy;
      done = bvalid;
      if (done) chk("bresp", 34'(bresp), 34'(eb));
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [33:0] e);
    logic ta, done;
    exp_rd.push_back(e);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      ta = arv & arr;
      done = rvalid;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && exp_vec.size() > 0; i++) @(negedge clk);
    chk("left over", 34'(exp_vec.size()), 34'h0);
    // hand back on a rising edge so the caller's next stimulus lands there
    @(posedge clk);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    {rstn, awv, wv, bready, arv, rready, run, slow, sw_sb, hw_sb} = 10'h000;
    {awaddr, araddr, wdata, int_req} = 87'h0;
    nmi_n = 1'b1;
    ext_n = 3'h7;
    pause(3);
    rstn <= 1'b1;
    rd(`VIC_SENSE_IDX, 34'h0F8);
    rd(`VIC_ENABLE_IDX, 34'h0F8);
    rd(`VIC_SYSCTL_IDX, 34'h00B);
    rd(`VIC_COND_IDX, 34'h080);
    rd(`VIC_STATUS_IDX, 34'h0);
    d = $random(seed);
    wr(`VIC_SENSE_IDX, d, 2'h0);
    rd(`VIC_SENSE_IDX, {26'h0, 5'h1F, d[2:0]});
    wr(16'hFFC5, d, 2'h2);
    $display("test registers done");
    nmi_n <= 1'b0;
    pause(12);
    exp_vec.push_back(16'h0006);
    run <= 1'b1;
    drain();
    pause(20);
    wr(`VIC_SYSCTL_IDX, 32'h05, 2'h0);
    sw_sb <= 1'b1;
    nmi_n <= 1'b1;
    exp_vec.push_back(16'h0006);
    for (k = 0; k < 20 && !wake; k++) @(negedge clk);
    chk("wake", 34'(wake), 34'h1);
    @(posedge clk);
    sw_sb <= 1'b0;
    slow <= 1'b1;
    drain();
    nmi_n <= 1'b0;
    pause(40);
    // nmi caught during hardware standby waits until standby is left
    hw_sb <= 1'b1;
    nmi_n <= 1'b1;
    pause(40);
    exp_vec.push_back(16'h0006);
    hw_sb <= 1'b0;
    drain();
    pause(40);
    $display("test nmi done");
    wr(`VIC_SENSE_IDX, 32'h07, 2'h0);
    wr(`VIC_ENABLE_IDX, 32'h07, 2'h0);
    ext_n <= 3'h0;
    pause(4);
    ext_n <= 3'h7;
    pause(4);
    wr(`VIC_ENABLE_IDX, 32'h00, 2'h0);
    exp_vec = '{16'h0008, 16'h000A, 16'h000C};
    wr(`VIC_COND_IDX, 32'h00, 2'h0);
    drain();
    pause(40);
    wr(`VIC_COND_IDX, 32'h80, 2'h0);
    wr(`VIC_ENABLE_IDX, 32'h07, 2'h0);
    ext_n <= 3'h5;
    pause(4);
    ext_n <= 3'h7;
    pause(4);
    wr(`VIC_ENABLE_IDX, 32'h00, 2'h0);
    wr(`VIC_SENSE_IDX, 32'h00, 2'h0);
    wr(`VIC_SENSE_IDX, 32'h07, 2'h0);
    wr(`VIC_COND_IDX, 32'h00, 2'h0);
    pause(30);
    wr(`VIC_SENSE_IDX, 32'h00, 2'h0);
    ext_n <= 3'h3;
    pause(12);
    exp_vec.push_back(16'h000C);
    wr(`VIC_ENABLE_IDX, 32'h04, 2'h0);
    drain();
    ext_n <= 3'h7;
    pause(40);
    $display("test external done");
    en = 19'($random(seed));
    wr(`VIC_INTEN_IDX, {13'h0, en}, 2'h0);
    for (int i = 0; i < 19; i++) begin
      @(posedge clk);
      int_req <= 19'h1 << i;
      if (en[i]) exp_vec.push_back({9'h0, i < 13 ? 6'h0C + 6'(i) :
        i < 17 ? 6'h0E + 6'(i) : 6'h12 + 6'(i), 1'b0});
      pause(12);
      drain();
      int_req <= 19'h0;
      pause(40);
    end
    $display("test internal done");
    conclude();
  end
endmodule
`default_nettype wire
